// ---- sac_pkg.sv ----
package sac_pkg;

  // Converter word and sequence figures
  localparam int SAC_WIDTH = 8;
  localparam logic [3:0] SAC_BIT_EDGES = 4'd8;
  localparam logic [3:0] SAC_CNT_RST = 4'h0;

  // Trial and reset codes
  localparam logic [7:0] SAC_MSB_TRIAL = 8'h80;
  localparam logic [7:0] SAC_SAR_RST = 8'h00;
  localparam logic [7:0] SAC_DAC_RST = 8'h00;
  localparam logic [7:0] SAC_BUS_RST = 8'h00;

  // Pin synchroniser idle levels
  localparam logic SAC_START_IDLE = 1'b1;
  localparam logic SAC_LOW_IDLE = 1'b0;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HOLD,
    ST_RUN
  } sac_state_t;

  // Three-state result drive towards the converter bus
  typedef struct packed {
    logic oe;
    logic [SAC_WIDTH-1:0] data;
  } sac_drive_t;

endpackage

// ---- sac_pin_sync.sv ----
`timescale 1ns/1ps
module sac_pin_sync
  import sac_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Raw pin
  input wire logic [WIDTH-1:0] pinIn,
  // Filtered level and change pulses
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] level_r;
  logic agree;

  // Three flops; stage1 feeds only stage2 to contain metastability
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stage1_r <= RST_VAL;
      stage2_r <= RST_VAL;
      stage3_r <= RST_VAL;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // A change counts only once the last two stages agree
  assign agree = (stage2_r == stage3_r);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      level_r <= RST_VAL;
    end else if (agree) begin
      level_r <= stage3_r;
    end
  end

  // Pulses are combinational, one cycle ahead of the level update
  assign level = level_r;
  assign rise = {WIDTH{agree}} & stage3_r & ~level_r;
  assign fall = {WIDTH{agree}} & ~stage3_r & level_r;

endmodule

// ---- sac_converter.sv ----
`timescale 1ns/1ps
// Operation
// RULE_01: Start leads first falling edge by 1.5 us
// RULE_02: Start release avoids clock falls by 200 ns
// RULE_03: Start may equal one low clock pulse
// RULE_04: Active start forces code to MSB only
// RULE_05: Low start holds sequence, release lets proceed
// RULE_06: First fall decides MSB, trials next bit
// RULE_07: Each later fall decides current trial bit
// RULE_08: Done rises on ninth falling edge
// RULE_09: Result stays latched until next start
// RULE_10: Output enable low floats data outputs
// RULE_11: DAC latch transparent at zero, holds at one
// RULE_12: Host shares one 8-bit converter bus
// RULE_13: Host drives six individual select lines
// RULE_14: Host start line clears start flip-flop
// RULE_15: Start released on converter clock rising edge
// RULE_16: Up to four done outputs wired together
// RULE_17: Converter clock at or below 600 kHz
// RULE_18: Host may wait ten cycles instead
// RULE_19: Host enables only one converter per read
// RULE_20: Host writes data then pulses latch enable
// RULE_21: Host disables all converters before transfers
// RULE_22: Done low while conversion is in progress
// RULE_23: Host waits for done before new start
module sac_converter
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Converter clock and start, both asynchronous pins
  input wire logic convClkPin,
  input wire logic startConversionPulseN,
  // Analogue comparator and ladder code
  input wire logic trialAboveInput,
  output logic [SAC_WIDTH-1:0] trialCode,
  // Converter bus lines
  input wire logic outputEnablePin,
  input wire logic [SAC_WIDTH-1:0] converterBusLinesIn,
  output sac_drive_t resultDrive,
  output logic conversionDone,
  // Companion DAC latch
  input wire logic dacLatchEnablePin,
  output logic [SAC_WIDTH-1:0] dacCode
);

  sac_state_t state_r;
  logic [SAC_WIDTH-1:0] sar_r;
  logic [SAC_WIDTH-1:0] trialMask_r;
  logic [3:0] edgeCnt_r;
  logic done_r;
  logic oe_r;
  logic [SAC_WIDTH-1:0] busData_r;
  logic [SAC_WIDTH-1:0] dac_r;
  logic startLevel;
  logic convFall;
  logic compLevel;
  logic oeLevel;
  logic dacEnLevel;
  logic [SAC_WIDTH-1:0] busLevel;
  logic decideEdge;
  logic [SAC_WIDTH-1:0] sarDecided;

  // Start pin; idle high so reset does not look like a start
  sac_pin_sync #(.WIDTH(1), .RST_VAL(SAC_START_IDLE)) uStartSync (
    .clk(clk),
    .nrst(nrst),
    .pinIn(startConversionPulseN),
    .level(startLevel),
    .rise(),
    .fall()
  );

  // Converter clock only seen through its falling edges
  sac_pin_sync #(.WIDTH(1), .RST_VAL(SAC_LOW_IDLE)) uClkSync (
    .clk(clk),
    .nrst(nrst),
    .pinIn(convClkPin),
    .level(),
    .rise(),
    .fall(convFall)
  );

  // Comparator settles long before the next fall at 600 kHz or less
  sac_pin_sync #(.WIDTH(1), .RST_VAL(SAC_LOW_IDLE)) uCompSync (
    .clk(clk),
    .nrst(nrst),
    .pinIn(trialAboveInput),
    .level(compLevel),
    .rise(),
    .fall()
  );

  // Output enable select line
  sac_pin_sync #(.WIDTH(1), .RST_VAL(SAC_LOW_IDLE)) uOeSync (
    .clk(clk),
    .nrst(nrst),
    .pinIn(outputEnablePin),
    .level(oeLevel),
    .rise(),
    .fall()
  );

  // DAC latch enable select line
  sac_pin_sync #(.WIDTH(1), .RST_VAL(SAC_LOW_IDLE)) uDacEnSync (
    .clk(clk),
    .nrst(nrst),
    .pinIn(dacLatchEnablePin),
    .level(dacEnLevel),
    .rise(),
    .fall()
  );

  // Shared bus data, filtered as a whole word
  sac_pin_sync #(.WIDTH(SAC_WIDTH), .RST_VAL(SAC_BUS_RST)) uBusSync (
    .clk(clk),
    .nrst(nrst),
    .pinIn(converterBusLinesIn),
    .level(busLevel),
    .rise(),
    .fall()
  );

  // One decision per fall for the first eight falls of a run
  assign decideEdge = (state_r == ST_RUN) && startLevel && convFall &&
                      (edgeCnt_r < SAC_BIT_EDGES);

  // Drop the trial bit if the trial exceeds the input, try the next
  assign sarDecided = (sar_r & ~(compLevel ? trialMask_r : SAC_SAR_RST)) |
                      (trialMask_r >> 1); // [RULE_06] [RULE_07]

  // Sequencer; a low start overrides every state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else if (!startLevel) begin
      state_r <= ST_HOLD; // [RULE_05] [RULE_14]
    end else begin
      case (state_r)
        ST_HOLD: begin
          state_r <= ST_RUN; // [RULE_15]
        end
        ST_RUN: begin
          if (convFall && (edgeCnt_r == SAC_BIT_EDGES)) begin
            state_r <= ST_IDLE; // [RULE_08]
          end
        end
        ST_IDLE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Falling edge count within a run
  always_ff @(posedge clk) begin
    if (!nrst) begin
      edgeCnt_r <= SAC_CNT_RST;
    end else if (!startLevel) begin
      edgeCnt_r <= SAC_CNT_RST; // [RULE_05]
    end else if ((state_r == ST_RUN) && convFall) begin
      edgeCnt_r <= edgeCnt_r + 4'h1;
    end
  end

  // Approximation register doubles as the latched result
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sar_r <= SAC_SAR_RST;
      trialMask_r <= SAC_SAR_RST;
    end else if (!startLevel) begin
      sar_r <= SAC_MSB_TRIAL; // [RULE_04]
      trialMask_r <= SAC_MSB_TRIAL;
    end else if (decideEdge) begin
      sar_r <= sarDecided; // [RULE_06] [RULE_07]
      trialMask_r <= trialMask_r >> 1;
    end
  end

  // Done low from start until the ninth fall, then held to next start
  always_ff @(posedge clk) begin
    if (!nrst) begin
      done_r <= 1'b0;
    end else if (!startLevel) begin
      done_r <= 1'b0; // [RULE_22]
    end else if ((state_r == ST_RUN) && convFall &&
                 (edgeCnt_r == SAC_BIT_EDGES)) begin
      done_r <= 1'b1; // [RULE_08] [RULE_16]
    end
  end

  // Three-state drive follows the enable; data shows the held code
  always_ff @(posedge clk) begin
    if (!nrst) begin
      oe_r <= 1'b0;
      busData_r <= SAC_SAR_RST;
    end else begin
      oe_r <= oeLevel; // [RULE_10] [RULE_19]
      busData_r <= sar_r; // [RULE_09] [RULE_12]
    end
  end

  // DAC latch, transparent while its enable is low
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dac_r <= SAC_DAC_RST;
    end else if (!dacEnLevel) begin
      dac_r <= busLevel; // [RULE_11] [RULE_20]
    end
  end

  // Outputs
  assign trialCode = sar_r;
  assign resultDrive = '{oe: oe_r, data: busData_r};
  assign conversionDone = done_r;
  assign dacCode = dac_r;

  // Checks
  a_start_forces_msb: assert property ( // [RULE_04]
    @(posedge clk) disable iff (!nrst)
    !startLevel |=> (sar_r == SAC_MSB_TRIAL) && !done_r)
    else $error("active start did not force the msb code");

  a_hold_no_advance: assert property ( // [RULE_05]
    @(posedge clk) disable iff (!nrst)
    (!startLevel && $past(!startLevel)) |=> $stable(sar_r) &&
    (edgeCnt_r == SAC_CNT_RST))
    else $error("sequence advanced while start held low");

  a_decide_trial_bit: assert property ( // [RULE_07]
    @(posedge clk) disable iff (!nrst)
    decideEdge |=> (((sar_r & $past(trialMask_r)) != SAC_SAR_RST) ==
    !$past(compLevel)) && (trialMask_r == ($past(trialMask_r) >> 1)))
    else $error("trial bit decided against the comparator");

  a_msb_then_next: assert property ( // [RULE_06]
    @(posedge clk) disable iff (!nrst)
    (decideEdge && (edgeCnt_r == SAC_CNT_RST)) |=>
    sar_r[SAC_WIDTH-2] && (sar_r[SAC_WIDTH-1] == !$past(compLevel)))
    else $error("first fall did not set up bit two");

  a_done_ninth_edge: assert property ( // [RULE_08]
    @(posedge clk) disable iff (!nrst)
    $rose(done_r) |-> ($past(edgeCnt_r) == SAC_BIT_EDGES) &&
    $past(convFall) && (trialMask_r == SAC_SAR_RST))
    else $error("done rose away from the ninth falling edge");

  a_result_held: assert property ( // [RULE_09]
    @(posedge clk) disable iff (!nrst)
    (done_r && startLevel) |=> $stable(sar_r) && done_r)
    else $error("result changed before next start");

  a_drive_follows_oe: assert property ( // [RULE_10]
    @(posedge clk) disable iff (!nrst)
    oeLevel |=> resultDrive.oe ##1 (resultDrive.data == $past(sar_r)))
    else $error("output drive did not follow the enable");

  a_dac_latch_hold: assert property ( // [RULE_11]
    @(posedge clk) disable iff (!nrst)
    dacEnLevel |=> $stable(dacCode))
    else $error("dac code changed while latch closed");

  a_dac_latch_pass: assert property ( // [RULE_11]
    @(posedge clk) disable iff (!nrst)
    !dacEnLevel |=> (dacCode == $past(busLevel)))
    else $error("dac latch not transparent");

  a_done_low_busy: assert property ( // [RULE_22]
    @(posedge clk) disable iff (!nrst)
    (state_r == ST_RUN) |-> !done_r)
    else $error("done high during conversion");

  c_conversion_done: cover property (@(posedge clk) disable iff (!nrst)
    $rose(done_r));

  c_start_restart: cover property (@(posedge clk) disable iff (!nrst)
    done_r ##1 !startLevel);

  c_dac_capture: cover property (@(posedge clk) disable iff (!nrst)
    !dacEnLevel ##1 dacEnLevel);

endmodule

// ---- sac_host_model.sv ----
`timescale 1ns/1ps
module sac_host_model
  import sac_pkg::*;
(
  // Host side controls
  input wire logic hostStartN,
  input wire logic hostDrive,
  input wire logic [SAC_WIDTH-1:0] hostData,
  input wire logic [SAC_WIDTH-1:0] analogueLevel,
  // Converter side
  input wire logic [SAC_WIDTH-1:0] trialCode,
  input wire sac_drive_t resultDrive,
  output logic convClk,
  output logic startN,
  output logic trialAboveInput,
  output logic [SAC_WIDTH-1:0] busLines
);
  // Free-running clock, 588 kHz stays under the accuracy ceiling
  initial convClk = 1'b1;
  always #850 convClk = ~convClk;

  // Start flop: host clears it, converter clock rise sets it, so the
  // release sits half a period away from every fall
  initial startN = 1'b1;
  always @(posedge convClk or negedge hostStartN) begin
    if (!hostStartN) begin
      startN <= 1'b0;
    end else begin
      startN <= 1'b1;
    end
  end

  // Ideal comparator against the ladder code
  assign trialAboveInput = trialCode > analogueLevel;

  // Shared bus; no pull, so a released bus shows inverted data
  assign busLines = resultDrive.oe ? resultDrive.data :
    (hostDrive ? hostData : ~hostData);
endmodule

// ---- sac_converter_test.sv ----
`timescale 1ns/1ps
module sac_converter_test
  import sac_pkg::*;
;
  logic clk;
  logic nrst;
  logic hostStartN;
  logic hostDrive;
  logic [7:0] hostData;
  logic [7:0] level;
  logic oePin;
  logic dacEnPin;
  logic convClk;
  logic startN;
  logic above;
  logic [7:0] trialCode;
  logic [7:0] bus;
  sac_drive_t resultDrive;
  logic conversionDone;
  logic [7:0] dacCode;
  int n_fail = 0;
  int checked = 0;
  int falls = 0;
  int base = 0;
  logic [7:0] levels [5] = '{8'h00, 8'hff, 8'h80, 8'h7f, 8'h01};

  // 20 MHz system clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // Converter clock falls, counted to place the done edge
  always @(negedge convClk) falls <= falls + 1;

  sac_host_model host (.hostStartN(hostStartN), .hostDrive(hostDrive),
    .hostData(hostData), .analogueLevel(level), .trialCode(trialCode),
    .resultDrive(resultDrive), .convClk(convClk), .startN(startN),
    .trialAboveInput(above), .busLines(bus));

  sac_converter uut (.clk(clk), .nrst(nrst), .convClkPin(convClk),
    .startConversionPulseN(startN), .trialAboveInput(above),
    .trialCode(trialCode), .outputEnablePin(oePin),
    .converterBusLinesIn(bus), .resultDrive(resultDrive),
    .conversionDone(conversionDone), .dacLatchEnablePin(dacEnPin),
    .dacCode(dacCode));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Start pulse from the host line; long holds span several falls
  task automatic convert(input logic [7:0] v, input int hold);
    int i;
    level <= v;
    hostStartN <= 1'b0;
    tick(hold);
    chk("trial in hold", 8'h80, trialCode);
    chk("done in hold", 8'h00, 8'(conversionDone));
    hostStartN <= 1'b1;
    for (i = 0; i < 100 && startN !== 1'b1; i++) tick(1);
    if (i == 100) begin
      n_fail++;
      $display("[ERR] start release expected 1 seen %b", startN);
      test_done();
    end else begin
      base = falls;
    end
  endtask

  // Bounded wait for done, then fall count and result
  task automatic waitDone(input logic [7:0] v);
    int i;
    for (i = 0; i < 1000 && conversionDone !== 1'b1; i++) tick(1);
    if (i == 1000) begin
      n_fail++;
      $display("[ERR] done expected 1 seen %b", conversionDone);
      test_done();
    end else begin
      chk("falls to done", 8'd9, 8'(falls - base));
      // Ten converter periods of 34 system clocks bound a fixed wait
      chk("done in ten", 8'h01, 8'(i <= 340));
      chk("result", v, trialCode);
    end
  endtask

  initial begin
    int k;
    nrst = 1'b0;
    hostStartN = 1'b1;
    hostDrive = 1'b0;
    hostData = 8'h00;
    level = 8'h00;
    oePin = 1'b0;
    dacEnPin = 1'b1;
    tick(10);
    chk("reset trial", 8'h00, trialCode);
    chk("reset dac", 8'h00, dacCode);
    chk("reset oe", 8'h00, 8'(resultDrive.oe));
    chk("reset done", 8'h00, 8'(conversionDone));
    nrst <= 1'b1;
    tick(2);
    // Long hold first, then the result must outlive input changes
    convert(8'ha5, 100);
    waitDone(8'ha5);
    level <= 8'h3c;
    tick(80);
    chk("latched result", 8'ha5, trialCode);
    chk("done held", 8'h01, 8'(conversionDone));
    // One converter enabled, host bus released
    oePin <= 1'b1;
    tick(6);
    chk("oe on", 8'h01, 8'(resultDrive.oe));
    chk("bus data", 8'ha5, bus);
    oePin <= 1'b0;
    tick(6);
    chk("oe off", 8'h00, 8'(resultDrive.oe));
    // Back-to-back conversions at the code extremes and either side of mid-scale
    foreach (levels[j]) begin
      convert(levels[j], 20);
      waitDone(levels[j]);
    end
    // Restart in mid conversion; the second code must win
    convert(8'h55, 20);
    for (k = 0; k < 400 && falls - base < 4; k++) tick(1);
    if (k == 400) begin
      n_fail++;
      $display("[ERR] restart falls expected 4 seen %0d", falls - base);
      test_done();
    end else begin
      convert(8'h2a, 20);
      waitDone(8'h2a);
    end
    // Latch follows while enabled, ignores bus once held
    for (k = 0; k < 2; k++) begin
      hostDrive <= 1'b1;
      hostData <= k[0] ? 8'h3c : 8'hc3;
      dacEnPin <= 1'b0;
      tick(8);
      chk("dac open", k[0] ? 8'h3c : 8'hc3, dacCode);
      dacEnPin <= 1'b1;
      tick(6);
      hostData <= k[0] ? 8'hc3 : 8'h3c;
      tick(8);
      chk("dac held", k[0] ? 8'h3c : 8'hc3, dacCode);
      hostDrive <= 1'b0;
      tick(1);
    end
    test_done();
  end
endmodule
